// ==== design/rtc_gate_defines.svh ====
`ifndef RTC_GATE_DEFINES_SVH
`define RTC_GATE_DEFINES_SVH

// ==========================================================
// special-function register addresses on the core's bus
`define SFR_SELECT_ADDR   8'hac
`define SFR_DATA_ADDR     8'had
`define SFR_KEY_ADDR      8'hae

// ==========================================================
// key codes and lock status codes
`define KEY_FIRST         8'ha5
`define KEY_SECOND        8'hf1
`define CODE_LOCKED       8'h00
`define CODE_FIRST        8'h01
`define CODE_UNLOCKED     8'h02
`define CODE_DISABLED     8'h03
`define BYTE_ZERO         8'h00

// ==========================================================
// indirect select field positions
`define SEL_BUSY_BIT      7
`define SEL_AUTO_BIT      6
`define SEL_SHORT_BIT     4
`define SEL_ADDR_MSB      3

// ==========================================================
// power-on values of the retained select register
`define SEL_POR_SHORT     1'b1
`define SEL_POR_AUTO      1'b0
`define SEL_POR_ADDR      4'h0

// ==========================================================
// access timing in system clock cycles
`define ACC_CYC_LONG      3'h7
`define ACC_CYC_SHORT     3'h6
`define CNT_ONE           3'h1
`define CNT_ZERO          3'h0

// ==========================================================
// indirect address windows that autoincrement
`define SNAP_LO           4'h0
`define SNAP_HI           4'h3
`define WAKE_LO           4'h8
`define WAKE_HI           4'hb
`define ADDR_STEP         4'h1

`endif

// ==== design/rtc_gate_pkg.sv ====
package rtc_gate_pkg;

   // ==========================================================
   // lock and key states, one-hot
   typedef enum logic [3:0]
   {
      GATE_LOCKED   = 4'b0001,
      GATE_FIRST    = 4'b0010,
      GATE_OPEN     = 4'b0100,
      GATE_DISABLED = 4'b1000
   } gate_state_t;

   // ==========================================================
   // transfer engine states, one-hot
   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'b01,
      ENG_RUN  = 2'b10
   } eng_state_t;

   // request from the processor core's register bus
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // strobes and data toward the internal clock registers
   typedef struct packed
   {
      logic       wr_stb;
      logic       rd_stb;
      logic [3:0] addr;
      logic [7:0] wdata;
   } rtc_req_t;

   // state cleared by system reset
   typedef struct packed
   {
      gate_state_t gate;
      eng_state_t  eng;
      logic        op_read;
      logic [2:0]  cnt;
      logic [7:0]  rdata;
   } core_t;

   // state that survives a system reset
   typedef struct packed
   {
      logic       auto_fetch_en;
      logic       short_en;
      logic [3:0] addr;
      logic [7:0] data;
   } keep_t;

endpackage

// ==== design/rtc_indirect_access_gate.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rtc_gate_defines.svh"

module rtc_indirect_access_gate
#(
   parameter logic [2:0] ACC_CYC_LONG  = `ACC_CYC_LONG,  // normal access length
   parameter logic [2:0] ACC_CYC_SHORT = `ACC_CYC_SHORT  // short strobe length
)
(
   input  wire logic                   sys_clk,   // system clock, 100 MHz
   input  wire logic                   rst_b,     // system reset, async, low
   input  wire logic                   por_b,     // power-on reset, async, low
   input  wire rtc_gate_pkg::sfr_req_t sfr_req,   // core register bus request
   output var  logic [7:0]             sfr_rdata, // read data, one cycle late
   output var  rtc_gate_pkg::rtc_req_t rtc_req,   // strobes to internal regs
   input  wire logic [7:0]             rtc_rdata  // selected internal reg value
);
   import rtc_gate_pkg::*;

   // the block runs on the core's clock alone; the internal
   // registers behind it answer for the selected address in
   // the same clock, so no crossing logic is needed here, and
   // the core's request arrives already on this clock
   // ==========================================================
   // state registers
   core_t core_r;    // lock state, engine, read-back
   core_t core_nxt;  // next value of core_r
   keep_t keep_r;    // select and data, kept over system reset
   keep_t keep_nxt;  // next value of keep_r

   // ==========================================================
   // status code for a lock state
   // pure decode, so a status read can never move the state
   function automatic logic [7:0] gate_code(input gate_state_t g);
      logic [7:0] code;
      code = `CODE_LOCKED;
      case (g)
         GATE_LOCKED:   code = `CODE_LOCKED;
         GATE_FIRST:    code = `CODE_FIRST;
         GATE_OPEN:     code = `CODE_UNLOCKED;
         GATE_DISABLED: code = `CODE_DISABLED;
         default:       code = `CODE_LOCKED;
      endcase
      return code;
   endfunction

   // ==========================================================
   // true for a capture or alarm byte address
   // the two windows hold the 32-bit snapshot and wake match
   // values, so a byte run walks through one whole value
   function automatic logic in_window(input logic [3:0] a);
      logic hit;
      hit = 1'b0;
      if ((a >= `SNAP_LO) && (a <= `SNAP_HI))
      begin
         hit = 1'b1;
      end
      if ((a >= `WAKE_LO) && (a <= `WAKE_HI))
      begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // ==========================================================
   // next-state logic for the whole block
   always_comb
   begin
      logic wr_key;    // write to the key register
      logic wr_sel;    // write to the select register
      logic wr_dat;    // write to the data register
      logic rd_key;    // read of the key register
      logic rd_sel;    // read of the select register
      logic rd_dat;    // read of the data register
      logic open;      // gate currently unlocked
      logic idle;      // no transfer under way
      logic start;     // a transfer begins this cycle
      logic start_rd;  // the transfer that begins is a read
      logic busy;      // busy flag as seen by software
      wr_key   = 1'b0;
      wr_sel   = 1'b0;
      wr_dat   = 1'b0;
      rd_key   = 1'b0;
      rd_sel   = 1'b0;
      rd_dat   = 1'b0;
      open     = 1'b0;
      idle     = 1'b0;
      start    = 1'b0;
      start_rd = 1'b0;
      busy     = 1'b0;
      core_nxt = core_r;
      keep_nxt = keep_r;

      // decode of the core's access
      wr_key = sfr_req.wr && (sfr_req.addr == `SFR_KEY_ADDR);
      wr_sel = sfr_req.wr && (sfr_req.addr == `SFR_SELECT_ADDR);
      wr_dat = sfr_req.wr && (sfr_req.addr == `SFR_DATA_ADDR);
      rd_key = sfr_req.rd && (sfr_req.addr == `SFR_KEY_ADDR);
      rd_sel = sfr_req.rd && (sfr_req.addr == `SFR_SELECT_ADDR);
      rd_dat = sfr_req.rd && (sfr_req.addr == `SFR_DATA_ADDR);
      open   = (core_r.gate == GATE_OPEN);
      idle   = (core_r.eng == ENG_IDLE);
      busy   = (core_r.eng == ENG_RUN);

      // lock and key sequence; only writes and data reads move it, so a
      // status read in the middle of a sequence is harmless
      if (wr_key)
      begin
         case (core_r.gate)
            GATE_LOCKED:
            begin
               // elapsed time is never looked at, only order
               if (sfr_req.wdata == `KEY_FIRST)
               begin
                  core_nxt.gate = GATE_FIRST;
               end
               else
               begin
                  core_nxt.gate = GATE_DISABLED;
               end
            end
            GATE_FIRST:
            begin
               if (sfr_req.wdata == `KEY_SECOND)
               begin
                  core_nxt.gate = GATE_OPEN;
               end
               else
               begin
                  core_nxt.gate = GATE_DISABLED;
               end
            end
            GATE_OPEN:
            begin
               // any value relocks; a transfer already running
               // is allowed to finish
               core_nxt.gate = GATE_LOCKED;
            end
            GATE_DISABLED:
            begin
               core_nxt.gate = GATE_DISABLED;
            end
            default:
            begin
               // a corrupted code is treated as locked, never open
               core_nxt.gate = GATE_LOCKED;
            end
         endcase
      end
      else if ((wr_sel || wr_dat || rd_dat) && !open)
      begin
         // writing select, or writing or reading data, while locked is fatal
         // until the next system reset
         core_nxt.gate = GATE_DISABLED;
      end

      // select register write, dropped while busy so that
      // the target of a running transfer cannot move
      if (wr_sel && open && idle)
      begin
         keep_nxt.auto_fetch_en = sfr_req.wdata[`SEL_AUTO_BIT];
         keep_nxt.short_en      = sfr_req.wdata[`SEL_SHORT_BIT];
         keep_nxt.addr          = sfr_req.wdata[`SEL_ADDR_MSB:0];
         if (sfr_req.wdata[`SEL_BUSY_BIT])
         begin
            start    = 1'b1;
            start_rd = 1'b1;
         end
      end

      // the byte is latched at once although it only leaves
      // when the strobe fires, so it stays readable meanwhile
      // data register write starts an indirect write
      if (wr_dat && open && idle)
      begin
         keep_nxt.data = sfr_req.wdata;
         start         = 1'b1;
         start_rd      = 1'b0;
      end

      // autoread: a data read chains the next fetch; the
      // byte returned is the one already held
      if (rd_dat && open && idle && keep_r.auto_fetch_en)
      begin
         start    = 1'b1;
         start_rd = 1'b1;
      end

      // transfer engine
      // one counted run per transfer; requests that arrive while
      // it runs are dropped, not queued, which keeps the host
      // contract simple: poll busy, then ask again
      case (core_r.eng)
         ENG_IDLE:
         begin
            if (start)
            begin
               core_nxt.eng     = ENG_RUN;
               core_nxt.op_read = start_rd;
               // length follows the short bit as just written
               if (keep_nxt.short_en)
               begin
                  core_nxt.cnt = ACC_CYC_SHORT - `CNT_ONE;
               end
               else
               begin
                  core_nxt.cnt = ACC_CYC_LONG - `CNT_ONE;
               end
            end
         end
         ENG_RUN:
         begin
            if (core_r.cnt == `CNT_ZERO)
            begin
               // last cycle: strobe fires, busy drops next edge
               core_nxt.eng = ENG_IDLE;
               if (core_r.op_read)
               begin
                  // held until a data write or the end of the next read
                  keep_nxt.data = rtc_rdata;
               end
               if (in_window(keep_r.addr))
               begin
                  keep_nxt.addr = 4'(keep_r.addr + `ADDR_STEP);
               end
            end
            else
            begin
               core_nxt.cnt = 3'(core_r.cnt - `CNT_ONE);
            end
         end
         default:
         begin
            // a corrupted code falls back to idle
            core_nxt.eng = ENG_IDLE;
         end
      endcase

      // the status read only looks at core_r.gate, which keeps
      // key reads free of side effects
      // read-back, registered; select and data read as zero
      // unless the gate is open
      if (rd_key)
      begin
         core_nxt.rdata = gate_code(core_r.gate);
      end
      else if (rd_sel && open)
      begin
         core_nxt.rdata = {busy, keep_r.auto_fetch_en, 1'b0,
                           keep_r.short_en, keep_r.addr};
      end
      else if (rd_dat && open)
      begin
         core_nxt.rdata = keep_r.data;
      end
      else if (sfr_req.rd)
      begin
         core_nxt.rdata = `BYTE_ZERO;
      end
   end

   // ==========================================================
   // lock state and engine, cleared by system reset
   // the read-back byte sits here too, so a system reset
   // never leaves stale data visible to the core
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         core_r.gate    <= GATE_LOCKED;
         core_r.eng     <= ENG_IDLE;
         core_r.op_read <= 1'b0;
         core_r.cnt     <= `CNT_ZERO;
         core_r.rdata   <= `BYTE_ZERO;
      end
      else
      begin
         core_r <= core_nxt;
      end
   end

   // ==========================================================
   // select and data live on the power-on reset only, so a
   // system reset leaves them untouched
   // limitation: without por_b at power-up these flops start
   // unknown, so both resets must be asserted at power-up
   always_ff @(posedge sys_clk or negedge por_b)
   begin
      if (!por_b)
      begin
         keep_r.auto_fetch_en <= `SEL_POR_AUTO;
         keep_r.short_en      <= `SEL_POR_SHORT;
         keep_r.addr          <= `SEL_POR_ADDR;
         keep_r.data          <= `BYTE_ZERO;
      end
      else
      begin
         keep_r <= keep_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign sfr_rdata = core_r.rdata;

   // decoding from registers only keeps the strobes free of
   // glitches toward the internal registers
   // strobes are decoded from the engine registers; address
   // and data come straight from the select and data flops
   assign rtc_req.wr_stb = (core_r.eng == ENG_RUN) && (core_r.cnt == `CNT_ZERO)
                           && !core_r.op_read;
   assign rtc_req.rd_stb = (core_r.eng == ENG_RUN) && (core_r.cnt == `CNT_ZERO)
                           && core_r.op_read;
   assign rtc_req.addr   = keep_r.addr;
   assign rtc_req.wdata  = keep_r.data;

endmodule
`default_nettype wire

// ==== verif/rtc_gate_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================
// port checks of the indirect access gate
module rtc_gate_chk
#(
   parameter logic [2:0] ACC_CYC_LONG  = 3'h7, // normal access length
   parameter logic [2:0] ACC_CYC_SHORT = 3'h6  // short strobe length
)
(
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic                   por_b,
   input wire rtc_gate_pkg::sfr_req_t sfr_req,
   input wire logic [7:0]             sfr_rdata,
   input wire rtc_gate_pkg::rtc_req_t rtc_req,
   input wire logic [7:0]             rtc_rdata
);
   import rtc_gate_pkg::*;
   wire logic dwr = sfr_req.wr && sfr_req.addr == 8'had; // data write
   wire logic drd = sfr_req.rd && sfr_req.addr == 8'had; // data read
   wire logic rgo = drd || (sfr_req.wr && sfr_req.addr == 8'hac && sfr_req.wdata[7]);
   // address windows that step after an access
   wire logic win = rtc_req.addr <= 4'h3 || (rtc_req.addr >= 4'h8 && rtc_req.addr <= 4'hb);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ====================
   // sequences
   sequence s_stb; rtc_req.wr_stb || rtc_req.rd_stb; endsequence
   sequence s_data_rd; drd; endsequence
   property p_pulse; s_stb |=> !(rtc_req.wr_stb || rtc_req.rd_stb); endproperty
   property p_one; !(rtc_req.wr_stb && rtc_req.rd_stb); endproperty
   property p_wr_cause;
      rtc_req.wr_stb |-> $past(dwr, ACC_CYC_SHORT) || $past(dwr, ACC_CYC_LONG);
   endproperty
   property p_rd_cause;
      rtc_req.rd_stb |-> $past(rgo, ACC_CYC_SHORT) || $past(rgo, ACC_CYC_LONG);
   endproperty
   property p_code; sfr_req.rd && sfr_req.addr == 8'hae |=> sfr_rdata <= 8'h03; endproperty
   property p_incr; s_stb ##0 win |=> rtc_req.addr == $past(rtc_req.addr) + 4'h1; endproperty
   property p_no_incr; s_stb ##0 !win |=> $stable(rtc_req.addr); endproperty
   property p_hold; rtc_req.rd_stb ##1 s_data_rd |=> sfr_rdata == $past(rtc_rdata, 2); endproperty
   a_pulse: assert property (p_pulse) else $error("strobe wider than one cycle");
   a_one: assert property (p_one) else $error("read and write strobes together");
   a_wr_cause: assert property (p_wr_cause) else $error("write strobe off time");
   a_rd_cause: assert property (p_rd_cause) else $error("read strobe off time");
   a_code: assert property (p_code) else $error("bad lock status code");
   a_incr: assert property (p_incr) else $error("address did not step");
   a_no_incr: assert property (p_no_incr) else $error("address stepped");
   a_hold: assert property (p_hold) else $error("fetched byte lost");
endmodule
bind rtc_indirect_access_gate rtc_gate_chk
   #(.ACC_CYC_LONG(ACC_CYC_LONG), .ACC_CYC_SHORT(ACC_CYC_SHORT)) chk_i
   (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .rtc_req(rtc_req), .rtc_rdata(rtc_rdata));
`default_nettype wire

// ==== verif/rtc_gate_regs_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================
// internal clock registers behind the gate
module rtc_gate_regs_model
(
   input  wire logic                   sys_clk,   // system clock
   input  wire rtc_gate_pkg::rtc_req_t rtc_req,   // strobes from the gate
   output var  logic [7:0]             rtc_rdata  // selected register value
);
   import rtc_gate_pkg::*;
   logic [7:0] mem [16]; // snapshot 0-3, wake match 8-b
   // known preset so fetched bytes are predictable
   initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 37 + 11);
   // a write strobe stores the byte at the selected address
   always @(posedge sys_clk)
      if (rtc_req.wr_stb) mem[rtc_req.addr] <= rtc_req.wdata;
   // junk outside the strobe: the gate must sample in the strobe cycle
   always_comb rtc_rdata = rtc_req.rd_stb ? mem[rtc_req.addr] : ~mem[rtc_req.addr];
endmodule
`default_nettype wire

// ==== verif/rtc_indirect_access_gate_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module rtc_indirect_access_gate_test;
   import rtc_gate_pkg::*;
   logic       sys_clk = 1'b0;  // 100 MHz
   logic       rst_b   = 1'b0;  // system reset
   logic       por_b   = 1'b0;  // power-on reset
   sfr_req_t   sfr_req = '0;    // core bus request
   rtc_req_t   rtc_req;         // gate to registers
   logic [7:0] sfr_rdata, rtc_rdata, v;
   logic [15:0] lfsr_r = 16'hbe1a; // fixed seed
   int fail_count = 0, checks = 0, n, s, stb_count = 0;
   always #5 sys_clk = ~sys_clk;
   rtc_indirect_access_gate rtc_indirect_access_gate_i (.sys_clk(sys_clk), .rst_b(rst_b),
      .por_b(por_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .rtc_req(rtc_req),
      .rtc_rdata(rtc_rdata));
   rtc_gate_regs_model rtc_gate_regs_model_i (.sys_clk(sys_clk), .rtc_req(rtc_req),
      .rtc_rdata(rtc_rdata));
   // counts every internal strobe, to prove nothing leaks while disabled
   always @(posedge sys_clk)
   begin
      if (rtc_req.wr_stb || rtc_req.rd_stb)
      begin
         stb_count <= stb_count + 1;
      end
   end
   // ====================
   // helpers
   function automatic logic [15:0] step(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // expected select read-back: busy, autoread, zero, short, address
   function automatic logic [7:0] sel_code(input logic b, input logic a, input logic s,
                                           input logic [3:0] ad);
      return {b, a, 1'b0, s, ad};
   endfunction
   // one bus cycle; read data lands in v one cycle later
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge sys_clk);
      sfr_req = '0;
      v = sfr_rdata;
   endtask
   // host waits out the transfer instead of fixed spacing
   task automatic wait_stb;
      n = 1;
      while (!(rtc_req.wr_stb || rtc_req.rd_stb) && n < 20)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 20)
      begin
         fail_count++;
         end_of_test();
      end
   endtask
   task automatic do_reset(input logic pwr);
      rst_b = 1'b0;
      por_b = !pwr;
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      por_b = 1'b1;
   endtask
   task automatic end_of_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ====================
   // main sequence
   initial
   begin
      do_reset(1'b1);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h00)
      bus(1, 8'hae, 8'ha5);
      repeat (lfsr_r[3:0]) @(negedge sys_clk);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h01)
      bus(1, 8'hae, 8'hf1);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h02)
      // short strobe writes, snapshot bytes 0-3
      bus(1, 8'hac, 8'h10);
      for (int i = 0; i < 4; i++)
      begin
         lfsr_r = step(lfsr_r);
         bus(1, 8'had, lfsr_r[7:0]);
         wait_stb();
         `CHK(n, 6)
         @(negedge sys_clk);
         `CHK(rtc_gate_regs_model_i.mem[i], lfsr_r[7:0])
      end
      bus(0, 8'hac, 0);
      `CHK(v, sel_code(1'b0, 1'b0, 1'b1, 4'h4))
      // long strobe, address outside the stepping windows
      bus(1, 8'hac, 8'h07);
      bus(1, 8'had, 8'h5a);
      wait_stb();
      `CHK(n, 7)
      bus(0, 8'hac, 0);
      `CHK(v, sel_code(1'b0, 1'b0, 1'b0, 4'h7))
      // fetch snapshot byte 0
      bus(1, 8'hac, 8'h90);
      bus(0, 8'hac, 0);
      `CHK(v, sel_code(1'b1, 1'b0, 1'b1, 4'h0))
      wait_stb();
      bus(0, 8'had, 0);
      `CHK(v, rtc_gate_regs_model_i.mem[0])
      bus(0, 8'had, 0);
      `CHK(v, rtc_gate_regs_model_i.mem[0])
      // autoread over the wake match bytes
      bus(1, 8'hac, 8'hd8);
      for (int i = 0; i < 4; i++)
      begin
         wait_stb();
         `CHK(n, 6)
         bus(0, 8'had, 0);
         `CHK(v, rtc_gate_regs_model_i.mem[8 + i])
      end
      wait_stb();
      bus(0, 8'hac, 0);
      `CHK(v, sel_code(1'b0, 1'b1, 1'b1, 4'hc))
      lfsr_r = step(lfsr_r);
      bus(1, 8'hae, lfsr_r[7:0]);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h00)
      s = stb_count;
      bus(1, 8'had, 8'h3c);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h03)
      bus(1, 8'hae, 8'ha5);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h03)
      bus(0, 8'had, 0);
      `CHK(v, 8'h00)
      repeat (10) @(negedge sys_clk);
      `CHK(stb_count, s)
      // system reset only
      do_reset(1'b0);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h00)
      bus(1, 8'hae, 8'ha5);
      bus(1, 8'hae, 8'hf1);
      bus(0, 8'hac, 0);
      `CHK(v, sel_code(1'b0, 1'b1, 1'b1, 4'hc))
      bus(0, 8'had, 0);
      `CHK(v, rtc_gate_regs_model_i.mem[12])
      do_reset(1'b0);
      bus(1, 8'hae, 8'ha5);
      bus(1, 8'hae, 8'h00);
      bus(0, 8'hae, 0);
      `CHK(v, 8'h03)
      end_of_test();
   end
endmodule
`default_nettype wire
